// ==== src/pfc_loop_ctrl.sv ====
// loop mode, data format, scheduling and handover control with avalon-mm registers
// Overview of operation
// - table address errors: below, above, system area
// - position form default, velocity form selectable
// - sample period 50 ms to 99.99 s
// - calculations run only after ladder task ends
// - forward or reverse action on setpoint minus process
// - type a manual-to-auto: setpoint follows, bias too in position form
// - type a auto-to-cascade: major output takes process
// - type b: only bias follows, position form
// - handover type from mode word one bit 3
// - common format shared, independent format separate
// - unipolar ranges 4095, 32767, 65535
// - bipolar is sign-magnitude, 4095 or 32767
// - no bipolar with 16-bit format
// - manual: no calculation, output word untouched
// - automatic: output written every sample period
// - manual straight to cascade is refused
// - program mode forces manual, run restores mode
// - setpoint confined to limits when enabled
// - cascade setpoint comes from major loop output
// - calculated output kept within upper and lower limits; manual writes are not limited
// - mode requests on rising bits 0, 1, 2
// - current mode shown in monitor bits 0-2
// - mode word two bit 10 selects independent format
`default_nettype none
module pfc_loop_ctrl
   import pfc_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
) (
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RESET_I,
   // avalon-mm slave
   input wire logic [7:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // controller scan
   input wire logic RUN_MODE_I,
   input wire logic LADDER_DONE_I,
   // process and cascade partner
   input wire logic [15:0] PV_I,
   input wire logic [15:0] REMOTE_SP_I,
   output logic [15:0] CTRL_OUT_O,
   output logic FORCE_MAJOR_O,
   output logic [15:0] FORCE_VALUE_O
);
   typedef struct packed {
      logic [15:0] mode1, mode2, sp, sp_lo, sp_hi, out_lo, out_hi, period;
      logic [15:0] kp, ki, kd, rs_addr, rs_err, ctrl_out, force_val, pv_m, pv_s;
      pfc_mode_t mode;
      pfc_mode_t prev_eff;
      logic run_q;
      logic ack;
      logic [31:0] rdata;
      logic [23:0] tick_cnt;
      logic [13:0] samp_cnt;
      logic due;
      logic force_major;
   } pfc_state_t;
   pfc_state_t r, n;

   // ****************************************
   // data format helpers
   // ****************************************
   function automatic pfc_val_t fmt_max(input logic f15, input logic f16);
      if (f16) return MAX_16;
      if (f15) return MAX_15;
      return MAX_12;
   endfunction

   // bipolar words are magnitude plus sign in bit 15, never two's complement
   function automatic pfc_val_t to_val(input logic [15:0] raw, input logic bip);
      if (bip && raw[15]) return -$signed({3'b000, raw[14:0]});
      if (bip) return $signed({3'b000, raw[14:0]});
      return $signed({2'b00, raw});
   endfunction

   function automatic logic [15:0] to_raw(input pfc_val_t v, input logic bip);
      pfc_val_t mag;
      mag = (v < 0) ? -v : v;
      if (bip) return {v < 0, mag[14:0]};
      return v[15:0];
   endfunction

   function automatic pfc_val_t clip(input pfc_val_t v, input pfc_val_t lo, input pfc_val_t hi);
      if (v < lo) return lo;
      if (v > hi) return hi;
      return v;
   endfunction

   function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wd,
      input logic [3:0] be);
      return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // ****************************************
   // format decode and values
   // ****************************************
   logic in_bip, out_bip, ind, bus_req, wr_go, rd_go, start, m2a, a2c;
   logic [2:0] rise;
   logic [13:0] per;
   logic [15:0] calc_raw, pv_fit;
   pfc_val_t in_max, in_min, out_max, out_min, pv_v, sp_lo_v, sp_hi_v, sp_cur;
   pfc_mode_t eff;
   pfc_calc_if calc();

   assign in_bip = r.mode2[M2_BIP] & ~r.mode2[M2_F16];
   assign in_max = fmt_max(r.mode2[M2_F15], r.mode2[M2_F16]);
   assign ind = r.mode2[M2_IND];
   assign out_bip = ind ? (r.mode2[M2_OBIP] & ~r.mode2[M2_OF16]) : in_bip;
   assign out_max = ind ? fmt_max(r.mode2[M2_OF15], r.mode2[M2_OF16]) : in_max;
   assign in_min = in_bip ? -in_max : '0;
   assign out_min = out_bip ? -out_max : '0;
   assign pv_v = clip(to_val(r.pv_s, in_bip), in_min, in_max);
   assign sp_lo_v = to_val(r.sp_lo, in_bip);
   assign sp_hi_v = to_val(r.sp_hi, in_bip);
   assign sp_cur = to_val(r.sp, in_bip);

   // setpoint path used by software writes, the remote source and handover
   function automatic logic [15:0] sp_fit(input pfc_val_t v);
      pfc_val_t t;
      t = clip(v, in_min, in_max);
      if (r.mode2[M2_SPLIM]) t = clip(t, sp_lo_v, sp_hi_v);
      return to_raw(t, in_bip);
   endfunction

   assign pv_fit = sp_fit(pv_v);
   // program mode parks the loop in manual without losing the stored mode
   assign eff = RUN_MODE_I ? r.mode : MODE_MAN;
   assign m2a = (r.prev_eff == MODE_MAN) && (eff == MODE_AUTO);
   assign a2c = (r.prev_eff == MODE_AUTO) && (eff == MODE_CAS);
   assign per = (r.period < PERIOD_MIN) ? PERIOD_MIN[13:0] :
      (r.period > PERIOD_MAX) ? PERIOD_MAX[13:0] : r.period[13:0];
   assign start = r.due & LADDER_DONE_I & RUN_MODE_I;

   // ****************************************
   // bus handshake
   // ****************************************
   // every access costs two cycles; read data is latched in the first one
   assign bus_req = AVS_READ_I | AVS_WRITE_I;
   assign AVS_WAITREQUEST_O = bus_req & ~r.ack;
   assign wr_go = AVS_WRITE_I & r.ack;
   assign rd_go = AVS_READ_I & ~r.ack;

   // ****************************************
   // arithmetic unit
   // ****************************************
   assign calc.start = start & (eff != MODE_MAN);
   assign calc.load_bias = m2a & ~r.mode1[M1_VEL];
   assign calc.velocity = r.mode1[M1_VEL];
   assign calc.reverse = r.mode1[M1_REV];
   assign calc.sp = (eff == MODE_CAS) ? to_val(sp_fit(to_val(REMOTE_SP_I, in_bip)), in_bip)
      : sp_cur;
   assign calc.pv = pv_v;
   assign calc.out_now = to_val(r.ctrl_out, out_bip);
   assign calc.lo = clip(to_val(r.out_lo, out_bip), out_min, out_max);
   assign calc.hi = clip(to_val(r.out_hi, out_bip), out_min, out_max);
   assign calc.kp = r.kp;
   assign calc.ki = r.ki;
   assign calc.kd = r.kd;
   assign calc_raw = to_raw(calc.out, out_bip);

   pfc_calc u_calc (
      .clk_i(CLOCK_I),
      .rst_i(RESET_I),
      .bus(calc.calc)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      n = r;
      rise = '0;
      n.ack = bus_req & ~r.ack;
      n.pv_m = PV_I;
      n.pv_s = r.pv_m;
      n.run_q = RUN_MODE_I;
      n.prev_eff = eff;
      n.force_major = 1'b0;
      if (rd_go) begin
         n.rdata = '0;
         case (AVS_ADDRESS_I)
            OFS_MODE1: n.rdata[15:0] = r.mode1;
            OFS_MODE2: n.rdata[15:0] = r.mode2;
            OFS_SP: n.rdata[15:0] = r.sp;
            OFS_PV: n.rdata[15:0] = r.pv_s;
            OFS_PERIOD: n.rdata[15:0] = r.period;
            OFS_OUT: n.rdata[15:0] = r.ctrl_out;
            OFS_MON: n.rdata[2:0] = eff;
            OFS_SP_LO: n.rdata[15:0] = r.sp_lo;
            OFS_SP_HI: n.rdata[15:0] = r.sp_hi;
            OFS_OUT_LO: n.rdata[15:0] = r.out_lo;
            OFS_OUT_HI: n.rdata[15:0] = r.out_hi;
            OFS_KP: n.rdata[15:0] = r.kp;
            OFS_KI: n.rdata[15:0] = r.ki;
            OFS_KD: n.rdata[15:0] = r.kd;
            OFS_RS_ADDR: n.rdata[15:0] = r.rs_addr;
            OFS_RS_ERR: n.rdata[15:0] = r.rs_err;
            default: n.rdata = '0;
         endcase
      end
      if (wr_go) begin
         case (AVS_ADDRESS_I)
            OFS_MODE1: begin
               n.mode1 = be_merge(r.mode1, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
               rise = n.mode1[M1_CAS:M1_MAN] & ~r.mode1[M1_CAS:M1_MAN];
            end
            OFS_MODE2: n.mode2 = be_merge(r.mode2, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            OFS_SP: n.sp = sp_fit(to_val(be_merge(r.sp, AVS_WRITEDATA_I, AVS_BYTEENABLE_I),
               in_bip));
            OFS_PERIOD: n.period = be_merge(r.period, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            OFS_OUT: begin
               // the operator owns the output word only while the loop is manual
               if (eff == MODE_MAN) begin
                  n.ctrl_out = be_merge(r.ctrl_out, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
               end
            end
            OFS_SP_LO: n.sp_lo = be_merge(r.sp_lo, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            OFS_SP_HI: n.sp_hi = be_merge(r.sp_hi, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            OFS_OUT_LO: n.out_lo = be_merge(r.out_lo, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            OFS_OUT_HI: n.out_hi = be_merge(r.out_hi, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            OFS_KP: n.kp = be_merge(r.kp, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            OFS_KI: n.ki = be_merge(r.ki, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            OFS_KD: n.kd = be_merge(r.kd, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            OFS_RS_ADDR: n.rs_addr = be_merge(r.rs_addr, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            default: ;
         endcase
      end
      // mode requests are only honoured in run mode; manual has priority
      if (RUN_MODE_I) begin
         if (rise[M1_MAN]) begin
            n.mode = MODE_MAN;
         end else if (rise[M1_AUTO]) begin
            n.mode = MODE_AUTO;
         end else if (rise[M1_CAS] && r.mode != MODE_MAN) begin
            n.mode = MODE_CAS;
         end
      end
      // table pointer is checked once, when the controller enters run mode
      if (RUN_MODE_I && !r.run_q) begin
         n.rs_err = '0;
         n.rs_err[ERR_LO] = r.rs_addr < VMEM_LO;
         n.rs_err[ERR_HI] = r.rs_addr > VMEM_HI;
         n.rs_err[ERR_SYS] = (r.rs_addr >= SYS_LO) && (r.rs_addr <= SYS_HI);
      end
      if (m2a && !r.mode1[M1_XFER]) begin
         n.sp = pv_fit;
      end
      if (a2c && !r.mode1[M1_XFER]) begin
         n.force_major = 1'b1;
         n.force_val = r.pv_s;
      end
      if (calc.done && eff != MODE_MAN) begin
         n.ctrl_out = calc_raw;
      end
      // sample scheduler: clear on launch first so a new period end wins
      if (start) begin
         n.due = 1'b0;
      end
      if (RUN_MODE_I) begin
         if (r.tick_cnt == 24'(TICK_CYC - 1)) begin
            n.tick_cnt = '0;
            if (r.samp_cnt + 14'd1 >= per) begin
               n.samp_cnt = '0;
               n.due = 1'b1;
            end else begin
               n.samp_cnt = r.samp_cnt + 14'd1;
            end
         end else begin
            n.tick_cnt = r.tick_cnt + 24'd1;
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         r <= '0;
         r.mode <= MODE_MAN;
         r.prev_eff <= MODE_MAN;
         r.period <= RST_PERIOD;
         r.sp_hi <= RST_SP_HI;
         r.out_hi <= RST_OUT_HI;
      end else begin
         r <= n;
      end
   end

   assign AVS_READDATA_O = r.rdata;
   assign CTRL_OUT_O = r.ctrl_out;
   assign FORCE_MAJOR_O = r.force_major;
   assign FORCE_VALUE_O = r.force_val;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RESET_I);

   sequence s_ladder_end;
      LADDER_DONE_I && r.due && RUN_MODE_I && eff != MODE_MAN;
   endsequence

   sequence s_auto_done;
      calc.done && eff == MODE_AUTO;
   endsequence

   a_table_low_flag: assert property (
      RUN_MODE_I && !r.run_q && !wr_go |=> r.rs_err[ERR_LO] == (r.rs_addr < VMEM_LO)
      && r.rs_err[ERR_HI] == (r.rs_addr > VMEM_HI))
      else $error("table address flags wrong after run entry");
   a_sample_count: assert property (
      $rose(r.due) |-> $past(r.samp_cnt) + 14'd1 >= $past(per))
      else $error("sample due before its period");
   a_calc_after_ladder: assert property (
      s_ladder_end |-> calc.start ##1 calc.done)
      else $error("calculation not launched at ladder end");
   a_handover_sp: assert property (
      m2a && !r.mode1[M1_XFER] |=> r.sp == $past(pv_fit))
      else $error("setpoint did not follow process value");
   a_major_force: assert property (
      a2c && !r.mode1[M1_XFER] |=> r.force_major ##1 !r.force_major)
      else $error("major loop force pulse missing");
   a_manual_hold: assert property (
      eff == MODE_MAN && !(wr_go && AVS_ADDRESS_I == OFS_OUT) |=> $stable(r.ctrl_out))
      else $error("output word changed in manual");
   a_auto_write: assert property (
      s_auto_done |=> r.ctrl_out == $past(calc_raw))
      else $error("automatic result not written");
   a_no_man_cas: assert property (
      r.mode == MODE_MAN |=> r.mode != MODE_CAS)
      else $error("manual went straight to cascade");
   a_program_keep: assert property (
      !RUN_MODE_I |=> $stable(r.mode))
      else $error("stored mode lost in program mode");
   a_sp_limit: assert property (
      wr_go && AVS_ADDRESS_I == OFS_SP && r.mode2[M2_SPLIM] && sp_lo_v <= sp_hi_v
      && !m2a |=> sp_cur >= sp_lo_v && sp_cur <= sp_hi_v)
      else $error("setpoint outside its limits");
endmodule
`default_nettype wire

// ==== src/pfc_pkg.sv ====
// shared constants and types for the loop mode and format control block
`default_nettype none
package pfc_pkg;
   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_MODE1 = 8'h00;
   localparam logic [7:0] OFS_MODE2 = 8'h04;
   localparam logic [7:0] OFS_SP = 8'h08;
   localparam logic [7:0] OFS_PV = 8'h0c;
   localparam logic [7:0] OFS_PERIOD = 8'h10;
   localparam logic [7:0] OFS_OUT = 8'h14;
   localparam logic [7:0] OFS_MON = 8'h18;
   localparam logic [7:0] OFS_SP_LO = 8'h1c;
   localparam logic [7:0] OFS_SP_HI = 8'h20;
   localparam logic [7:0] OFS_OUT_LO = 8'h24;
   localparam logic [7:0] OFS_OUT_HI = 8'h28;
   localparam logic [7:0] OFS_KP = 8'h2c;
   localparam logic [7:0] OFS_KI = 8'h30;
   localparam logic [7:0] OFS_KD = 8'h34;
   localparam logic [7:0] OFS_RS_ADDR = 8'h38;
   localparam logic [7:0] OFS_RS_ERR = 8'h3c;
   // ****************************************
   // field positions
   // ****************************************
   localparam int M1_MAN = 0;
   localparam int M1_AUTO = 1;
   localparam int M1_CAS = 2;
   localparam int M1_XFER = 3;
   localparam int M1_REV = 4;
   localparam int M1_VEL = 5;
   localparam int M2_BIP = 0;
   localparam int M2_F15 = 1;
   localparam int M2_SPLIM = 3;
   localparam int M2_F16 = 9;
   localparam int M2_IND = 10;
   localparam int M2_OBIP = 11;
   localparam int M2_OF15 = 12;
   localparam int M2_OF16 = 13;
   localparam int ERR_LO = 0;
   localparam int ERR_HI = 1;
   localparam int ERR_SYS = 4;
   // ****************************************
   // reset values, ranges and timing
   // ****************************************
   localparam logic [15:0] RST_PERIOD = 16'h0005;
   localparam logic [15:0] RST_SP_HI = 16'h0fff;
   localparam logic [15:0] RST_OUT_HI = 16'h0fff;
   localparam logic [15:0] PERIOD_MIN = 16'h0005;
   localparam logic [15:0] PERIOD_MAX = 16'h270f;
   localparam logic [15:0] VMEM_LO = 16'h0400;
   localparam logic [15:0] VMEM_HI = 16'h3fff;
   localparam logic [15:0] SYS_LO = 16'h3e00;
   localparam logic [15:0] SYS_HI = 16'h3fff;
   localparam int GAIN_SHIFT = 4;
   localparam int CLK_HZ = 10_000_000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   typedef logic signed [17:0] pfc_val_t;
   localparam pfc_val_t MAX_12 = 18'sh00fff;
   localparam pfc_val_t MAX_15 = 18'sh07fff;
   localparam pfc_val_t MAX_16 = 18'sh0ffff;
   typedef enum logic [2:0] {
      MODE_MAN = 3'b001,
      MODE_AUTO = 3'b010,
      MODE_CAS = 3'b100
   } pfc_mode_t;
endpackage
`default_nettype wire

// ==== src/pfc_calc_if.sv ====
// signals between the mode controller and the loop arithmetic unit
`default_nettype none
interface pfc_calc_if;
   logic start;
   logic load_bias;
   logic velocity;
   logic reverse;
   pfc_pkg::pfc_val_t sp;
   pfc_pkg::pfc_val_t pv;
   pfc_pkg::pfc_val_t out_now;
   pfc_pkg::pfc_val_t lo;
   pfc_pkg::pfc_val_t hi;
   pfc_pkg::pfc_val_t out;
   logic [15:0] kp;
   logic [15:0] ki;
   logic [15:0] kd;
   logic done;
   modport calc(input start, load_bias, velocity, reverse, sp, pv, out_now, lo, hi,
      kp, ki, kd, output done, out);
   modport ctl(output start, load_bias, velocity, reverse, sp, pv, out_now, lo, hi,
      kp, ki, kd, input done, out);
endinterface
`default_nettype wire

// ==== src/pfc_calc.sv ====
// loop arithmetic unit: error, p/i/d terms, position and velocity forms
`default_nettype none
module pfc_calc
   import pfc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // controller side
   pfc_calc_if.calc bus
);
   typedef logic signed [29:0] pfc_acc_t;
   typedef struct packed {
      pfc_val_t e1;
      pfc_val_t e2;
      pfc_val_t bias;
      pfc_val_t out;
      logic done;
   } pfc_calc_state_t;
   pfc_calc_state_t r, n;
   pfc_val_t e;
   pfc_acc_t ex, e1x, e2x;

   // only the low gain byte is used so no product can overflow the accumulator
   function automatic pfc_acc_t term(input logic [15:0] gain, input pfc_acc_t x);
      return ($signed({22'h000000, gain[7:0]}) * x) >>> GAIN_SHIFT;
   endfunction

   function automatic pfc_val_t sat(input pfc_acc_t v, input pfc_val_t lo, input pfc_val_t hi);
      if (v < pfc_acc_t'(lo)) return lo;
      if (v > pfc_acc_t'(hi)) return hi;
      return v[17:0];
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      n = r;
      n.done = 1'b0;
      e = bus.reverse ? bus.pv - bus.sp : bus.sp - bus.pv;
      ex = pfc_acc_t'(e);
      e1x = pfc_acc_t'(r.e1);
      e2x = pfc_acc_t'(r.e2);
      if (bus.load_bias) begin
         n.bias = bus.out_now;
      end
      if (bus.start) begin
         n.done = 1'b1;
         n.e1 = e;
         n.e2 = r.e1;
         if (bus.velocity) begin
            n.out = sat(pfc_acc_t'(bus.out_now) + term(bus.kp, ex - e1x) + term(bus.ki, ex)
               + term(bus.kd, ex - e1x - e1x + e2x), bus.lo, bus.hi);
         end else begin
            n.bias = sat(pfc_acc_t'(r.bias) + term(bus.ki, ex), bus.lo, bus.hi);
            n.out = sat(pfc_acc_t'(n.bias) + term(bus.kp, ex) + term(bus.kd, ex - e1x),
               bus.lo, bus.hi);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign bus.done = r.done;
   assign bus.out = r.out;

   a_out_in_limits: assert property (@(posedge clk_i) disable iff (rst_i)
      bus.start && bus.lo <= bus.hi |=> r.out >= $past(bus.lo) && r.out <= $past(bus.hi))
      else $error("control output left its limits");
endmodule
`default_nettype wire

// ==== dv/pfc_sensor_model.sv ====
// process sensor and cascade major loop stand-in for the loop controller
`default_nettype none
module pfc_sensor_model #(
   parameter int LAG = 3
) (
   // clock
   input wire logic clk_i,
   // values the bench wants the far side to present
   input wire logic [15:0] pv_set_i,
   input wire logic [15:0] major_set_i,
   // toward the controller
   output logic [15:0] pv_o,
   output logic [15:0] remote_sp_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] pipe [LAG];
   // a real sensor answers late: each new value crosses a conversion pipe
   always @(posedge clk_i) begin
      pipe[0] <= pv_set_i;
      for (int i = 1; i < LAG; i++) begin
         pipe[i] <= pipe[i - 1];
      end
      remote_sp_o <= major_set_i;
   end
   assign pv_o = pipe[LAG - 1];
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the loop mode and format controller
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import pfc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, run = 1'b0, lad = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0, rdq, rdq_smp;
   logic wreq, wreq_smp;
   logic [15:0] ta [4] = '{16'h0100, 16'h4000, 16'h3f00, 16'h2000};
   logic [31:0] te [4] = '{32'h1, 32'h2, 32'h10, 32'h0};
   logic [15:0] pv_set = 16'h0200, maj_set = 16'h0250, pv, rsp, cout, fval;
   logic fmaj;
   int miscompares = 0, total_checks = 0, fcnt = 0;
   logic [15:0] fseen;
   initial forever #50 clk = ~clk;
   pfc_loop_ctrl #(.TICK_CYC(10)) dut_u (.CLOCK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(adr),
      .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(4'hf), .AVS_WRITEDATA_I(wd),
      .AVS_READDATA_O(rdq), .AVS_WAITREQUEST_O(wreq), .RUN_MODE_I(run), .LADDER_DONE_I(lad),
      .PV_I(pv), .REMOTE_SP_I(rsp), .CTRL_OUT_O(cout), .FORCE_MAJOR_O(fmaj),
      .FORCE_VALUE_O(fval));
   pfc_sensor_model #(.LAG(3)) far_u (.clk_i(clk), .pv_set_i(pv_set),
      .major_set_i(maj_set), .pv_o(pv), .remote_sp_o(rsp));
   // ****************************************
   // sampling and bus tasks
   // ****************************************
   // sample mid-cycle so values are settled when the next edge uses them
   always @(negedge clk) begin
      wreq_smp = wreq;
      rdq_smp = rdq;
      if (fmaj === 1'b1) begin
         fcnt++;
         fseen = fval;
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
      output logic [31:0] q);
      int n;
      @(posedge clk);
      rd <= ~w;
      wr <= w;
      adr <= a;
      wd <= {16'h0, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq_smp !== 1'b0 && n < 20);
      q = rdq_smp;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         end_of_test();
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 16'h0, q);
      chk(what, q, exp);
   endtask
   // one sample period passes, then the ladder task reports its end
   task automatic scan();
      repeat (60) @(posedge clk);
      lad <= 1'b1;
      @(posedge clk);
      lad <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      end_of_test();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rchk("mode", OFS_MON, 32'h1);
      rchk("period", OFS_PERIOD, {16'h0, RST_PERIOD});
      rchk("out_hi", OFS_OUT_HI, {16'h0, RST_OUT_HI});
      rchk("unmapped", 8'hfc, 32'h0);
      wreg(OFS_RS_ERR, 16'hffff);
      rchk("err_ro", OFS_RS_ERR, 32'h0);
      for (int i = 0; i < 4; i++) begin
         run <= 1'b0;
         wreg(OFS_RS_ADDR, ta[i]);
         run <= 1'b1;
         repeat (3) @(posedge clk);
         rchk("table_err", OFS_RS_ERR, te[i]);
      end
      $display("test reset and table flags done");
      wreg(OFS_OUT, 16'h0123);
      scan();
      chk("manual_out", {16'h0, cout}, 32'h123);
      wreg(OFS_MODE1, 16'h0004);
      rchk("no_man_cas", OFS_MON, 32'h1);
      wreg(OFS_MODE1, 16'h0000);
      wreg(OFS_MODE1, 16'h0002);
      repeat (3) @(posedge clk);
      rchk("auto", OFS_MON, 32'h2);
      rchk("sp_follow", OFS_SP, 32'h200);
      $display("test manual and handover done");
      wreg(OFS_KP, 16'h0010);
      wreg(OFS_SP, 16'h0300);
      scan();
      chk("auto_out", {16'h0, cout}, 32'h223);
      // a new setpoint must not reach the output before the ladder task ends
      wreg(OFS_SP, 16'h0380);
      repeat (150) @(posedge clk);
      chk("no_ladder", {16'h0, cout}, 32'h223);
      wreg(OFS_OUT_HI, 16'h0200);
      scan();
      chk("out_limit", {16'h0, cout}, 32'h200);
      wreg(OFS_OUT_HI, 16'h0fff);
      wreg(OFS_SP, 16'h0300);
      wreg(OFS_MODE1, 16'h0012);
      scan();
      chk("reverse", {16'h0, cout}, 32'h23);
      wreg(OFS_MODE2, 16'h0008);
      wreg(OFS_SP_HI, 16'h0400);
      wreg(OFS_SP, 16'h0500);
      rchk("sp_limit", OFS_SP, 32'h400);
      $display("test automatic output done");
      wreg(OFS_MODE1, 16'h0016);
      repeat (6) @(posedge clk);
      chk("force_count", fcnt, 32'h1);
      chk("force_value", {16'h0, fseen}, 32'h200);
      rchk("cascade", OFS_MON, 32'h4);
      scan();
      chk("cascade_sp", {16'h0, cout}, 32'hd3);
      run <= 1'b0;
      repeat (3) @(posedge clk);
      rchk("program", OFS_MON, 32'h1);
      run <= 1'b1;
      repeat (3) @(posedge clk);
      rchk("restore", OFS_MON, 32'h4);
      $display("test cascade and program mode done");
      wreg(OFS_MODE1, 16'h0001);
      wreg(OFS_OUT, 16'h0100);
      wreg(OFS_MODE1, 16'h000a);
      rchk("type_b_sp", OFS_SP, 32'h400);
      scan();
      chk("type_b_bias", {16'h0, cout}, 32'h300);
      // velocity form is only ever paired with handover type a
      wreg(OFS_MODE1, 16'h0021);
      wreg(OFS_OUT, 16'h0100);
      wreg(OFS_MODE1, 16'h0022);
      rchk("vel_sp", OFS_SP, 32'h200);
      wreg(OFS_SP, 16'h0400);
      scan();
      chk("velocity", {16'h0, cout}, 32'h100);
      $display("test handover types done");
      wreg(OFS_MODE2, 16'h0000);
      wreg(OFS_SP, 16'h9fff);
      rchk("uni_12", OFS_SP, 32'hfff);
      wreg(OFS_MODE2, 16'h0001);
      wreg(OFS_SP, 16'h9fff);
      rchk("bip_12", OFS_SP, 32'h8fff);
      wreg(OFS_MODE2, 16'h0201);
      wreg(OFS_SP, 16'h9fff);
      rchk("no_bip_16", OFS_SP, 32'h9fff);
      $display("test data formats done");
      end_of_test();
   end
endmodule
`default_nettype wire
